/* rtl/utxc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module utxc_top
    import utxc_pkg::*;
(
    // Clock, reset, enable
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    // Configuration
    input wire utxc_cfg_t I_CFG,
    // Transmit buffer write
    input wire logic I_TX_WR,
    input wire logic [DATA_W-1:0] I_TX_DATA,
    output logic O_TX_READY,
    // Status and interrupt
    output logic O_SHIFT_REG_EMPTY_FLAG,
    output logic O_TX_IRQ,
    // Serial line
    output logic O_TXD
);
    logic f_ready, f_valid, f_pop;
    logic [DATA_W-1:0] f_data;

    utxc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(I_CLK),
        .rst_n(I_RSTN),
        .ce(I_CE),
        .in_valid(I_TX_WR),
        .in_ready(f_ready),
        .in_data(I_TX_DATA),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    // Last sub-period index for the selected oversampling
    function automatic logic [3:0] sub_last(input logic [MODE_W-1:0] mode);
        return mode[HS_BIT] ? SUB_HS_LAST : SUB_LS_LAST;
    endfunction

    utxc_state_t st_q, st_d;
    logic [NBITS-1:0] sh_q, sh_d;
    logic [3:0] bit_q, bit_d;
    logic [3:0] sub_q, sub_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic txd_q, txd_d, empty_q, empty_d, irq_q, irq_d, rdy_q, rdy_d;
    logic tick, sub_end, last_bit;

    // Frame sequencing
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        sub_d = sub_q;
        div_d = div_q;
        txd_d = txd_q;
        empty_d = empty_q;
        irq_d = 1'b0;
        f_pop = 1'b0;
        tick = (div_q == '0);
        sub_end = tick && (sub_q == sub_last(I_CFG.serial_mode_register));
        last_bit = (bit_q == 4'(NBITS - 1));
        rdy_d = f_ready;
        unique case (st_q)
            UTXC_IDLE: begin
                txd_d = 1'b1;
                if (f_valid) begin
                    f_pop = 1'b1;
                    sh_d = {1'b1, f_data, 1'b0};
                    st_d = UTXC_LOAD;
                    empty_d = 1'b0;
                end
            end
            UTXC_LOAD: begin
                // Start bit goes out on next edge
                txd_d = sh_q[0];
                bit_d = '0;
                sub_d = '0;
                div_d = I_CFG.baud_div;
                st_d = UTXC_SHIFT;
                if (I_CFG.tx_interrupt_select == TXI_CHAR) begin
                    irq_d = 1'b1;
                end
            end
            UTXC_SHIFT: begin
                div_d = tick ? I_CFG.baud_div : DIV_W'(div_q - 1'b1);
                if (tick) begin
                    sub_d = 4'(sub_q + 1'b1);
                end
                if (sub_end) begin
                    sub_d = '0;
                    if (last_bit) begin
                        if (f_valid) begin
                            // Back to back, stop fully elapsed
                            f_pop = 1'b1;
                            sh_d = {1'b1, f_data, 1'b0};
                            st_d = UTXC_LOAD;
                            txd_d = 1'b0;
                            if (I_CFG.tx_interrupt_select == TXI_EMPTY) begin
                                irq_d = 1'b1;
                            end
                        end else begin
                            // empty only once stop has left
                            empty_d = 1'b1;
                            st_d = UTXC_IDLE;
                            txd_d = 1'b1;
                            if (I_CFG.tx_interrupt_select == TXI_LAST ||
                                I_CFG.tx_interrupt_select == TXI_EMPTY) begin
                                irq_d = 1'b1;
                            end
                        end
                    end else begin
                        bit_d = 4'(bit_q + 1'b1);
                        sh_d = {1'b1, sh_q[NBITS-1:1]};
                        txd_d = sh_q[1];
                    end
                end
            end
            default: st_d = UTXC_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_q <= UTXC_IDLE;
            sh_q <= '1;
            bit_q <= '0;
            sub_q <= '0;
            div_q <= '0;
            txd_q <= 1'b1;
            empty_q <= 1'b1;
            irq_q <= 1'b0;
            rdy_q <= 1'b0;
        end else if (I_CE) begin
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            sub_q <= sub_d;
            div_q <= div_d;
            txd_q <= txd_d;
            empty_q <= empty_d;
            irq_q <= irq_d;
            rdy_q <= rdy_d;
        end
    end

    assign O_TXD = txd_q;
    assign O_SHIFT_REG_EMPTY_FLAG = empty_q;
    assign O_TX_IRQ = irq_q;
    assign O_TX_READY = rdy_q;
endmodule
`default_nettype wire

/* rtl/utxc_pkg.sv */
// Notes on behaviour
// - Select 01 raises transmit interrupt only after last stop bit leaves shifter.
// - Shift-register-empty flag stays low while shifter still holds bits.
// - Byte written while empty flag high starts transmitting immediately.
// - High-speed bit 3 picks four sub-periods per bit, else sixteen.
package utxc_pkg;
    // Mode register layout
    localparam int MODE_W = 8;
    localparam int HS_BIT = 3;
    localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
    // Interrupt select encodings
    localparam logic [1:0] TXI_CHAR = 2'h0;
    localparam logic [1:0] TXI_LAST = 2'h1;
    localparam logic [1:0] TXI_EMPTY = 2'h2;
    // Sub-periods per bit
    localparam logic [3:0] SUB_HS_LAST = 4'h3;
    localparam logic [3:0] SUB_LS_LAST = 4'hf;
    // Baud divisor width, data width, fifo depth
    localparam int DIV_W = 16;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int NBITS = 10;

    typedef struct packed {
        logic [1:0] tx_interrupt_select;
        logic [MODE_W-1:0] serial_mode_register;
        logic [DIV_W-1:0] baud_div;
    } utxc_cfg_t;

    typedef enum logic [1:0] {
        UTXC_IDLE = 2'b00,
        UTXC_LOAD = 2'b01,
        UTXC_SHIFT = 2'b11
    } utxc_state_t;
endpackage

/* rtl/utxc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module utxc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Pointer and occupancy update
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage has no reset; only valid words are read
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wp_q] <= in_data;
        end
    end

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rp_q];
endmodule
`default_nettype wire

/* bench/utxc_tx_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module utxc_tx_monitor
    import utxc_pkg::*;
(
    // Clock, reset, inputs
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire utxc_cfg_t I_CFG,
    input wire logic I_TX_WR,
    // Watched outputs
    input wire logic O_SHIFT_REG_EMPTY_FLAG,
    input wire logic O_TX_IRQ,
    input wire logic O_TXD
);
    logic [21:0] bit_len, run_q, run_d;
    logic last_q;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    // Line level run length; saturates so a long idle never wraps
    always_comb begin
        bit_len = (22'(I_CFG.baud_div) + 22'h1) << (I_CFG.serial_mode_register[HS_BIT] ? 2 : 4);
        run_d = (O_TXD != last_q) ? 22'h1 : run_q + 22'(~&run_q);
    end
    // Registers only
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            run_q <= '1;
            last_q <= 1'b1;
        end else begin
            run_q <= run_d;
            last_q <= O_TXD;
        end
    end
    sequence s_start;
        ##[1:3] !O_SHIFT_REG_EMPTY_FLAG ##[1:2] !O_TXD;
    endsequence
    a_empty_line_idle: assert property (O_SHIFT_REG_EMPTY_FLAG |-> O_TXD)
        else $error("line active with empty flag");
    a_write_starts: assert property (I_TX_WR && O_SHIFT_REG_EMPTY_FLAG |-> s_start)
        else $error("idle write did not start");
    a_last_irq_done: assert property (O_TX_IRQ && I_CFG.tx_interrupt_select == TXI_LAST
        |-> ##[0:1] (O_SHIFT_REG_EMPTY_FLAG && O_TXD)) else $error("early last irq");
    a_stop_full: assert property (!O_TXD && last_q |-> run_q >= bit_len)
        else $error("short stop bit");
    a_bit_full: assert property (O_TXD && !last_q |-> run_q >= bit_len)
        else $error("short low bit");
endmodule
bind utxc_top utxc_tx_monitor mon (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CFG(I_CFG),
    .I_TX_WR(I_TX_WR), .O_SHIFT_REG_EMPTY_FLAG(O_SHIFT_REG_EMPTY_FLAG),
    .O_TX_IRQ(O_TX_IRQ), .O_TXD(O_TXD));
`default_nettype wire

/* bench/utxc_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module utxc_line_model (
    // Line and bit timing
    input wire logic clk,
    input wire logic txd,
    input wire logic [21:0] bit_len,
    // Received stream
    output logic [7:0] rx_byte,
    output logic [7:0] rx_cnt,
    output logic frame_err
);
    // Sample mid-bit on the falling clock, away from the line's update edge
    initial begin
        rx_byte = 8'h00;
        rx_cnt = 8'h00;
        frame_err = 1'b0;
        forever begin
            @(negedge txd);
            repeat (bit_len / 2) @(negedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (bit_len) @(negedge clk);
                if (i < 8) rx_byte[i] = txd;
            end
            frame_err = frame_err | !txd;
            rx_cnt = rx_cnt + 8'h1;
        end
    end
endmodule
`default_nettype wire

/* bench/uart_tx_completion_timing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_tx_completion_timing_tb;
    import utxc_pkg::*;
    logic clk = 0, rst_n, wr = 0, ready, empty, irq, txd, frame_err;
    logic [7:0] data = 8'h00, rx_byte, rx_cnt;
    logic [21:0] bl = 22'd16;
    utxc_cfg_t cfg = '0;
    int bad_count = 0, check_count = 0, irq_n = 0;
    utxc_top dut (.I_CLK(clk), .I_RSTN(rst_n), .I_CE(1'b1), .I_CFG(cfg), .I_TX_WR(wr),
        .I_TX_DATA(data), .O_TX_READY(ready), .O_SHIFT_REG_EMPTY_FLAG(empty),
        .O_TX_IRQ(irq), .O_TXD(txd));
    utxc_line_model line (.clk(clk), .txd(txd), .bit_len(bl), .rx_byte(rx_byte),
        .rx_cnt(rx_cnt), .frame_err(frame_err));
    // Clock and interrupt pulse counter
    initial forever #50 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Burst of n bytes; beyond nine the buffer and shifter refuse the rest
    task automatic burst(input logic [1:0] sel, input logic hs, input int n);
        int got, i0, k;
        logic [7:0] c0;
        got = (n > 9) ? 9 : n;
        cfg.tx_interrupt_select <= sel;
        cfg.serial_mode_register <= hs ? 8'h08 : 8'h00;
        bl <= hs ? 22'd4 : 22'd16;
        repeat (16) @(posedge clk);
        check(8'(ready), 8'h1, "ready idle");
        i0 = irq_n;
        c0 = rx_cnt;
        for (int i = 0; i < n; i++) begin
            wr <= 1'b1;
            data <= 8'h30 + 8'(i);
            @(posedge clk);
        end
        wr <= 1'b0;
        #1;
        if (n > 9) check(8'(ready), 8'h0, "ready");
        for (k = 0; k < 3000 && !(rx_cnt == c0 + 8'(got) && empty === 1'b1); k++) @(posedge clk);
        repeat (3) @(posedge clk);
        check(rx_cnt - c0, 8'(got), "count");
        check(rx_byte, 8'h30 + 8'(got - 1), "byte");
        check(8'(frame_err), 8'h0, "stop");
        check(8'(irq_n - i0), (sel == 1) ? 8'h1 : (sel == 3) ? 8'h0 : 8'(got), "irq");
        $display("burst sel %0d hs %0d n %0d done", sel, hs, n);
    endtask
    // Reset driven by nonblocking assignment at time zero so the async reset edge is seen
    initial begin
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        burst(2'h1, 1'b1, 1);
        burst(2'h0, 1'b1, 3);
        burst(2'h1, 1'b1, 3);
        burst(2'h2, 1'b1, 3);
        burst(2'h3, 1'b1, 2);
        burst(2'h1, 1'b0, 12);
        stop_test;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test;
    end
endmodule
`default_nettype wire
